// *** inc/ipcf_pkg.sv ***
package ipcf_pkg;
  // ****************************************
  // Message codes and field layouts
  // ****************************************
  localparam logic [7:0] MSG_MCAST_UNREG_REQ = 8'h1a;
  localparam logic [7:0] MSG_MCAST_UNREG_ACK = 8'h1b;
  localparam int ADDR_BYTES = 16;
  localparam int RESERVED_BITS = 6;
  localparam int DISPATCH_NHC_BIT = 5;
  localparam logic [1:0] HC_NONE = 2'h0;
  localparam logic [1:0] HC_NH = 2'h1;
  localparam logic [1:0] HC_STATEFUL = 2'h2;
  localparam logic [1:0] HC_BOTH = 2'h3;
  localparam int PEER_ENTRIES = 4;
  localparam int PEER_IDX_W = 2;
  // ****************************************
  // APB register map
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CAPS = 8'h08;
  localparam logic [7:0] REG_ADDR0 = 8'h10;
  localparam logic [7:0] REG_HDR = 8'h20;
  localparam logic [7:0] REG_RXINFO = 8'h24;
  localparam logic [7:0] REG_RXADDR0 = 8'h30;
  localparam logic [7:0] REG_PEER = 8'h40;
  localparam logic [31:0] CAPS_RESET = 32'h0000_0003;
  localparam int CMD_W = 3;
  localparam logic [2:0] CMD_UNREG_REQ = 3'h1;
  localparam logic [2:0] CMD_UNREG_ACK = 3'h2;
  localparam logic [2:0] CMD_CONN_INIT = 3'h3;
  localparam logic [2:0] CMD_CONN_RESP = 3'h4;
  localparam logic [2:0] CMD_IP_HDR = 3'h5;
  typedef enum logic [1:0] {IPCF_IDLE, IPCF_SEND, IPCF_FLUSH} ipcf_tx_state_type;

  // Lower of requested and local capability, bitwise on the two schemes
  function automatic logic [1:0] ipcf_negotiate(input logic [1:0] req, input logic [1:0] caps);
    return req & caps;
  endfunction
endpackage

// *** core/ipcf_bitpacker.sv ***
`timescale 1ns/1ps
module ipcf_bitpacker
  import ipcf_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bit field input
  input wire logic bits_valid,
  input wire logic [7:0] bits_data,
  input wire logic [3:0] bits_count,
  input wire logic flush,
  // Byte output
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic flush_done
);
  logic [14:0] acc_reg, acc_next;
  logic [3:0] fill_reg, fill_next;
  logic byte_valid_reg, byte_valid_next;
  logic [7:0] byte_reg, byte_next;
  logic done_reg, done_next;
  logic [14:0] merged;
  logic [4:0] total;

  // ****************************************
  // MSB-first packing, no gaps between fields
  // ****************************************
  always_comb begin
    merged = acc_reg;
    total = {1'b0, fill_reg};
    if (bits_valid) begin
      merged = acc_reg | (15'({bits_data, 7'h00} >> fill_reg) & ~(15'h7fff >> (fill_reg + bits_count)));
      total = 5'(fill_reg + bits_count);
    end
    acc_next = merged;
    fill_next = total[3:0];
    byte_valid_next = 1'b0;
    byte_next = byte_reg;
    done_next = 1'b0;
    if (total >= 5'd8) begin
      byte_valid_next = 1'b1;
      byte_next = merged[14:7];
      acc_next = {merged[6:0], 8'h00};
      fill_next = 4'(total - 5'd8);
    end else if (flush && !bits_valid) begin
      if (fill_reg != 4'h0) begin
        byte_valid_next = 1'b1;
        byte_next = merged[14:7];
      end
      acc_next = 15'h0000;
      fill_next = 4'h0;
      done_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= 15'h0000;
      fill_reg <= 4'h0;
      byte_valid_reg <= 1'b0;
      byte_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      fill_reg <= fill_next;
      byte_valid_reg <= byte_valid_next;
      byte_reg <= byte_next;
      done_reg <= done_next;
    end
  end

  assign byte_valid = byte_valid_reg;
  assign byte_data = byte_reg;
  assign flush_done = done_reg;
endmodule

// *** core/ipcf_peer_table.sv ***
`timescale 1ns/1ps
module ipcf_peer_table
  import ipcf_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write port
  input wire logic wr_en,
  input wire logic [PEER_IDX_W-1:0] wr_idx,
  input wire logic [129:0] wr_data,
  // Read port
  input wire logic [PEER_IDX_W-1:0] rd_idx,
  output logic [129:0] rd_data
);
  logic [129:0] mem [PEER_ENTRIES];
  logic [129:0] rd_reg;

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_reg <= '0;
    end else begin
      rd_reg <= mem[rd_idx];
    end
  end

  assign rd_data = rd_reg;
endmodule

// *** core/ipcf_framer.sv ***
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module ipcf_framer
  import ipcf_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Outgoing byte stream
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  // Incoming connection signalling bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  // Raw packet pass-through
  input wire logic raw_valid,
  input wire logic [7:0] raw_data,
  input wire logic raw_last
);
  ipcf_tx_state_type state_reg, state_next;
  logic [127:0] addr_reg, addr_next;
  logic [1:0] caps_reg, caps_next;
  logic [1:0] neg_reg, neg_next;
  logic [31:0] hdr_reg, hdr_next;
  logic [CMD_W-1:0] cmd_reg, cmd_next;
  logic [4:0] idx_reg, idx_next;
  logic busy_reg, busy_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic tx_valid_reg, tx_valid_next;
  logic [7:0] tx_data_reg, tx_data_next;
  logic tx_last_reg, tx_last_next;
  logic [127:0] rxaddr_reg, rxaddr_next;
  logic [1:0] rxhc_reg, rxhc_next;
  logic [4:0] rxcnt_reg, rxcnt_next;
  logic rxdone_reg, rxdone_next;
  logic [PEER_IDX_W-1:0] peer_wr_reg, peer_wr_next;
  logic [PEER_IDX_W-1:0] peer_rd_reg, peer_rd_next;
  logic tbl_wr;
  logic [129:0] tbl_rd;
  logic pk_valid;
  logic [7:0] pk_bits;
  logic [3:0] pk_count;
  logic pk_flush;
  logic pk_byte_valid;
  logic [7:0] pk_byte;
  logic pk_done;
  logic apb_wr;
  logic apb_rd;
  logic [1:0] neg_val;

  // ****************************************
  // APB slave
  // ****************************************
  assign apb_wr = psel && penable && pwrite && !pready_reg;
  assign apb_rd = psel && penable && !pwrite && !pready_reg;
  assign neg_val = ipcf_negotiate(rxhc_reg, caps_reg);

  always_comb begin
    caps_next = caps_reg;
    addr_next = addr_reg;
    hdr_next = hdr_reg;
    peer_rd_next = peer_rd_reg;
    cmd_next = cmd_reg;
    // Command stands for the whole transfer, cleared on return to idle
    if (state_reg != IPCF_IDLE && state_next == IPCF_IDLE) begin
      cmd_next = 3'h0;
    end
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    if (apb_wr || apb_rd) begin
      pready_next = 1'b1;
    end
    if (apb_wr) begin
      case (paddr)
        REG_CTRL: cmd_next = (busy_reg || cmd_reg != 3'h0) ? cmd_next : pwdata[CMD_W-1:0];
        REG_CAPS: caps_next = pwdata[1:0];
        REG_HDR: hdr_next = pwdata;
        REG_PEER: peer_rd_next = pwdata[PEER_IDX_W-1:0];
        REG_ADDR0, REG_ADDR0 + 8'h04, REG_ADDR0 + 8'h08, REG_ADDR0 + 8'h0c:
          addr_next[127 - 32*paddr[3:2] -: 32] = pwdata;
        default: pslverr_next = 1'b1;
      endcase
    end
    if (apb_rd) begin
      case (paddr)
        REG_CTRL: prdata_next = {29'h0, cmd_reg};
        REG_STATUS: prdata_next = {28'h0, neg_reg, rxdone_reg, busy_reg};
        REG_CAPS: prdata_next = {30'h0, caps_reg};
        REG_HDR: prdata_next = hdr_reg;
        REG_RXINFO: prdata_next = {28'h0, neg_val, rxhc_reg};
        REG_PEER: prdata_next = {28'h0, tbl_rd[129:128], peer_rd_reg};
        REG_ADDR0, REG_ADDR0 + 8'h04, REG_ADDR0 + 8'h08, REG_ADDR0 + 8'h0c:
          prdata_next = addr_reg[127 - 32*paddr[3:2] -: 32];
        REG_RXADDR0, REG_RXADDR0 + 8'h04, REG_RXADDR0 + 8'h08, REG_RXADDR0 + 8'h0c:
          prdata_next = rxaddr_reg[127 - 32*paddr[3:2] -: 32];
        default: begin
          prdata_next = 32'h0000_0000;
          pslverr_next = 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Transmit sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    busy_next = busy_reg;
    neg_next = neg_reg;
    tx_valid_next = 1'b0;
    tx_data_next = tx_data_reg;
    tx_last_next = 1'b0;
    pk_valid = 1'b0;
    pk_bits = 8'h00;
    pk_count = 4'h0;
    pk_flush = 1'b0;
    case (state_reg)
      IPCF_IDLE: begin
        idx_next = 5'h00;
        if (cmd_reg != 3'h0) begin
          state_next = IPCF_SEND;
          busy_next = 1'b1;
        end else if (raw_valid && tx_ready) begin
          tx_valid_next = 1'b1;
          tx_data_next = raw_data;
          tx_last_next = raw_last;
        end
      end
      IPCF_SEND: begin
        if (tx_ready) begin
          case (cmd_reg)
            CMD_UNREG_REQ, CMD_UNREG_ACK: begin
              tx_valid_next = 1'b1;
              if (idx_reg == 5'h00) begin
                tx_data_next = (cmd_reg == CMD_UNREG_REQ) ? MSG_MCAST_UNREG_REQ : MSG_MCAST_UNREG_ACK;
              end else begin
                tx_data_next = addr_reg[127 - 8*(idx_reg - 5'h01) -: 8];
              end
              tx_last_next = (idx_reg == 5'(ADDR_BYTES));
            end
            CMD_CONN_INIT: begin
              tx_valid_next = 1'b1;
              if (idx_reg == 5'h00) begin
                tx_data_next = {6'h00, caps_reg};
              end else begin
                tx_data_next = addr_reg[127 - 8*(idx_reg - 5'h01) -: 8];
              end
              tx_last_next = (idx_reg == 5'(ADDR_BYTES));
            end
            CMD_CONN_RESP: begin
              tx_valid_next = 1'b1;
              tx_data_next = {6'h00, neg_val};
              tx_last_next = 1'b1;
              neg_next = neg_val;
            end
            default: begin
              // Dispatch, NH flag in bit 2, inline IP bits, NH octet
              case (idx_reg)
                5'h00: begin
                  pk_valid = 1'b1;
                  pk_bits = {hdr_reg[31:27], hdr_reg[26], hdr_reg[25:24]};
                  pk_count = 4'h8;
                end
                5'h01: begin
                  pk_valid = 1'b1;
                  pk_bits = hdr_reg[23:16];
                  pk_count = 4'h8;
                end
                5'h02: begin
                  pk_valid = 1'b1;
                  pk_bits = {hdr_reg[7:0]};
                  pk_count = hdr_reg[11:8];
                end
                5'h03: begin
                  pk_valid = hdr_reg[26];
                  pk_bits = hdr_reg[15:8] & 8'hf0 | {4'h0, hdr_reg[15:12]};
                  pk_count = hdr_reg[26] ? 4'h8 : 4'h0;
                end
                default: pk_valid = 1'b0;
              endcase
              if (idx_reg == 5'h04) begin
                state_next = IPCF_FLUSH;
              end
            end
          endcase
          if (tx_last_next) begin
            state_next = IPCF_IDLE;
          end
          idx_next = 5'(idx_reg + 5'h01);
        end
        if (pk_byte_valid) begin
          tx_valid_next = 1'b1;
          tx_data_next = pk_byte;
        end
      end
      IPCF_FLUSH: begin
        pk_flush = 1'b1;
        if (pk_byte_valid) begin
          tx_valid_next = 1'b1;
          tx_data_next = pk_byte;
        end
        if (pk_done) begin
          state_next = IPCF_IDLE;
          busy_next = 1'b0;
        end
      end
      default: state_next = IPCF_IDLE;
    endcase
    if (state_reg == IPCF_SEND && state_next == IPCF_IDLE) begin
      busy_next = 1'b0;
    end
  end

  // ****************************************
  // Signalling receiver
  // ****************************************
  always_comb begin
    rxaddr_next = rxaddr_reg;
    rxhc_next = rxhc_reg;
    rxcnt_next = rxcnt_reg;
    rxdone_next = rxdone_reg;
    peer_wr_next = peer_wr_reg;
    tbl_wr = 1'b0;
    if (state_reg == IPCF_SEND && cmd_reg == CMD_CONN_RESP && tx_ready) begin
      tbl_wr = 1'b1;
      peer_wr_next = 2'(peer_wr_reg + 2'h1);
    end
    if (rx_valid) begin
      if (rxcnt_reg == 5'h00) begin
        rxhc_next = rx_data[1:0];
        rxdone_next = 1'b0;
      end else if (rxcnt_reg <= 5'(ADDR_BYTES)) begin
        rxaddr_next = {rxaddr_reg[119:0], rx_data};
      end
      rxcnt_next = rx_last ? 5'h00 : 5'(rxcnt_reg + 5'h01);
      if (rx_last) begin
        rxdone_next = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= IPCF_IDLE;
      addr_reg <= '0;
      caps_reg <= CAPS_RESET[1:0];
      neg_reg <= HC_NONE;
      hdr_reg <= 32'h0000_0000;
      cmd_reg <= 3'h0;
      idx_reg <= 5'h00;
      busy_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
      tx_last_reg <= 1'b0;
      rxaddr_reg <= '0;
      rxhc_reg <= HC_NONE;
      rxcnt_reg <= 5'h00;
      rxdone_reg <= 1'b0;
      peer_wr_reg <= '0;
      peer_rd_reg <= '0;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      caps_reg <= caps_next;
      neg_reg <= neg_next;
      hdr_reg <= hdr_next;
      cmd_reg <= cmd_next;
      idx_reg <= idx_next;
      busy_reg <= busy_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      tx_valid_reg <= tx_valid_next;
      tx_data_reg <= tx_data_next;
      tx_last_reg <= tx_last_next;
      rxaddr_reg <= rxaddr_next;
      rxhc_reg <= rxhc_next;
      rxcnt_reg <= rxcnt_next;
      rxdone_reg <= rxdone_next;
      peer_wr_reg <= peer_wr_next;
      peer_rd_reg <= peer_rd_next;
    end
  end

  // ****************************************
  // Submodules
  // ****************************************
  ipcf_bitpacker u_packer (
    .pclk(pclk),
    .presetn(presetn),
    .bits_valid(pk_valid),
    .bits_data(pk_bits),
    .bits_count(pk_count),
    .flush(pk_flush),
    .byte_valid(pk_byte_valid),
    .byte_data(pk_byte),
    .flush_done(pk_done)
  );

  ipcf_peer_table u_table (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(tbl_wr),
    .wr_idx(peer_wr_reg),
    .wr_data({neg_val, rxaddr_reg}),
    .rd_idx(peer_rd_reg),
    .rd_data(tbl_rd)
  );

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tx_valid = tx_valid_reg;
  assign tx_data = tx_data_reg;
  assign tx_last = tx_last_reg;

  // ****************************************
  // Checks
  // ****************************************
  a_req_type: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == IPCF_SEND && cmd_reg == CMD_UNREG_REQ && idx_reg == 5'h00 && tx_ready)
    |=> (tx_valid && tx_data == MSG_MCAST_UNREG_REQ)) else $error("unregister request type wrong");
  a_ack_type: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == IPCF_SEND && cmd_reg == CMD_UNREG_ACK && idx_reg == 5'h00 && tx_ready)
    |=> (tx_valid && tx_data == MSG_MCAST_UNREG_ACK)) else $error("unregister ack type wrong");
  a_ack_echo: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == IPCF_SEND && cmd_reg == CMD_UNREG_ACK && idx_reg == 5'h01 && tx_ready)
    |=> (tx_data == $past(addr_reg[127:120]))) else $error("ack address not echoed");
  a_raw_pass: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == IPCF_IDLE && cmd_reg == 3'h0 && raw_valid && tx_ready)
    |=> (tx_valid && tx_data == $past(raw_data))) else $error("raw byte altered");
  a_resp_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == IPCF_SEND && cmd_reg == CMD_CONN_RESP && tx_ready)
    |=> (tx_data[7:2] == 6'h00 && tx_last)) else $error("responder data malformed");
  a_resp_le: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == IPCF_SEND && cmd_reg == CMD_CONN_RESP && tx_ready)
    |=> (tx_data[1:0] <= $past(rxhc_reg))) else $error("responder value above request");
  a_init_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == IPCF_SEND && cmd_reg == CMD_CONN_INIT && idx_reg == 5'h00 && tx_ready)
    |=> (tx_data == {6'h00, $past(caps_reg)})) else $error("initiator data malformed");
  a_flush_end: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == IPCF_FLUSH) |-> ##[0:3] (state_reg == IPCF_IDLE)) else $error("padding flush stuck");
  a_apb_one: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable) |-> ##[0:1] pready) else $error("apb no answer");
  c_unreg: cover property (@(posedge pclk) disable iff (!presetn) tx_last && $past(cmd_reg) == CMD_UNREG_REQ);
  c_resp: cover property (@(posedge pclk) disable iff (!presetn) tbl_wr);
  c_hdr: cover property (@(posedge pclk) disable iff (!presetn) pk_done);
endmodule

// *** test/ipcf_peer_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Far-side peer node
// ****************************************
module ipcf_peer_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Stream from the framer
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  // Signalling toward the framer
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last
);
  logic [8:0] got[$];
  logic stall = 1'b0;
  integer seed = 89;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h5a;
    rx_last = 1'b0;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tx_ready <= 1'b0;
    else
      tx_ready <= stall ? 1'($random(seed)) : 1'b1;
  end
  always @(posedge pclk) begin
    if (tx_valid === 1'b1)
      got.push_back({tx_last, tx_data});
  end
  // Reserved bits come in random, request and address whole
  task automatic send_sig(input logic [135:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_data <= b[135-8*i -: 8];
      rx_last <= (i == n - 1);
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;
  endtask
endmodule

// *** test/ipv6_convergence_pdu_framer_test.sv ***
`timescale 1ns/1ps
module ipv6_convergence_pdu_framer_test
  import ipcf_pkg::*;
();
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, raw_data, tx_data, rx_data;
  logic [31:0] pwdata, prdata, d, h;
  logic tx_valid, tx_last, tx_ready, rx_valid, rx_last, raw_valid, raw_last, e;
  logic [127:0] a;
  logic [1:0] c;
  logic [8:0] q[$];
  integer seed = 89;
  int bad_count = 0;
  int comparisons = 0;

  ipcf_framer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .raw_valid(raw_valid), .raw_data(raw_data), .raw_last(raw_last));
  ipcf_peer_model peer (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, ad, 32'h0);
    check(d & m, exp);
  endtask
  task automatic set_addr();
    a = {$random(seed), $random(seed), $random(seed), $random(seed)};
    for (int i = 0; i < 4; i++)
      apb(1'b1, REG_ADDR0 + 8'(4 * i), a[127-32*i -: 32]);
  endtask
  function automatic void build(input logic [7:0] first, input int n);
    q.delete();
    q.push_back({n == 0, first});
    for (int i = 0; i < n; i++)
      q.push_back({i == n - 1, a[127-8*i -: 8]});
  endfunction
  task automatic frame();
    int n;
    n = 0;
    while (peer.got.size() < q.size() && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    foreach (q[i])
      check(32'(peer.got[i]), 32'(q[i]));
    repeat (4) @(posedge pclk);
    check(peer.got.size(), q.size());
    peer.got.delete();
  endtask

  initial begin
    #200_000;
    bad_count++;
    summarize();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    raw_valid = 1'b0;
    raw_data = 8'h00;
    raw_last = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(REG_CAPS, CAPS_RESET, 32'hffff_ffff);
    rd_chk(8'h80, 32'h0, 32'hffff_ffff);
    check(32'(e), 32'h1);
    peer.stall = 1'b1;
    for (int k = 0; k < 2; k++) begin
      set_addr();
      apb(1'b1, REG_CTRL, 32'(k ? CMD_UNREG_ACK : CMD_UNREG_REQ));
      build(k ? MSG_MCAST_UNREG_ACK : MSG_MCAST_UNREG_REQ, 16);
      frame();
    end
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, REG_CAPS, 32'(k));
      set_addr();
      apb(1'b1, REG_CTRL, 32'(CMD_CONN_INIT));
      build({6'h00, 2'(k)}, 16);
      frame();
    end
    for (int r = 0; r < 4; r++) begin
      c = 2'($random(seed));
      apb(1'b1, REG_CAPS, 32'(c));
      a = {$random(seed), $random(seed), $random(seed), $random(seed)};
      peer.send_sig({6'($random(seed)), 2'(r), a}, 17);
      repeat (4) @(posedge pclk);
      rd_chk(REG_STATUS, 32'h2, 32'h3);
      rd_chk(REG_RXINFO, {28'h0, 2'(r) & c, 2'(r)}, 32'hf);
      for (int i = 0; i < 4; i++)
        rd_chk(REG_RXADDR0 + 8'(4 * i), a[127-32*i -: 32], 32'hffff_ffff);
      apb(1'b1, REG_CTRL, 32'(CMD_CONN_RESP));
      build({6'h00, 2'(r) & c}, 0);
      frame();
    end
    apb(1'b1, REG_PEER, 32'h3);
    rd_chk(REG_PEER, {28'h0, 2'd3 & c, 2'h3}, 32'hf);
    for (int k = 0; k < 3; k++) begin
      h = {5'($random(seed)), k == 2, 10'($random(seed)), k == 2 ? 4'hf : 4'h0, k == 1 ? 4'h8 : 4'h3,
        8'($random(seed))};
      apb(1'b1, REG_HDR, h);
      apb(1'b1, REG_CTRL, 32'(CMD_IP_HDR));
      q.delete();
      q.push_back({1'b0, h[31:24]});
      q.push_back({1'b0, h[23:16]});
      // Header is followed by payload, so no byte of it is marked last
      if (k == 2) begin
        q.push_back({1'b0, h[7:5], 5'h1f});
        q.push_back({1'b0, 8'he0});
      end else
        q.push_back({1'b0, h[7:0] & (k ? 8'hff : 8'he0)});
      frame();
    end
    peer.stall = 1'b0;
    q.delete();
    for (int i = 0; i < 6; i++) begin
      h = $random(seed);
      @(posedge pclk);
      raw_valid <= 1'b1;
      raw_data <= h[7:0];
      raw_last <= (i == 5);
      q.push_back({i == 5, h[7:0]});
    end
    @(posedge pclk);
    raw_valid <= 1'b0;
    raw_last <= 1'b0;
    frame();
    summarize();
  end
endmodule
